// File: sdr_dma_ctl_model.sv
// dma controller model answering the shared receive request pin
`timescale 1ns/100ps

// ============================================================
// one read of the receive buffer per falling edge of the request seen while enabled and not busy
module sdr_dma_ctl_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// control from the bench
	input  wire logic        i_en,
	input  wire logic        i_slow,
	// request pin and access strobes
	input  wire logic        i_req_b,
	output logic             o_start,
	output logic             o_done,
	output logic [15:0]      o_count
);
	logic       prev_q;                  // request level last cycle
	logic       busy_q;                  // access in flight
	logic [2:0] wait_q;                  // cycles until completion

	// edges seen while busy are ignored, after done only a new falling edge starts a read
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			{o_start, o_done, busy_q, wait_q, o_count} <= '0;
			prev_q <= 1'b1;
		end
		else
		begin
			prev_q  <= i_req_b;
			o_start <= 1'b0;
			o_done  <= 1'b0;
			if (!busy_q && i_en && prev_q && !i_req_b)
			begin
				busy_q  <= 1'b1;
				o_start <= 1'b1;
				wait_q  <= i_slow ? 3'h4 : 3'h1;
				o_count <= o_count + 16'h1;
			end
			else if (busy_q)
			begin
				o_done <= (wait_q == 3'h1);
				busy_q <= (wait_q != 3'h1);
				wait_q <= wait_q - 3'h1;
			end
		end
	end
endmodule // sdr_dma_ctl_model

// File: sdr_dma_req.sv
// receive queue and dma request logic for one serial channel
//Function
//- dedicated tx request holds through buffer write
//- registers update cycles after access completes
//- dedicated tracks full; shared pin drops early
//- framing, d0, d4 give dedicated early drop
//- d7 d6 d5 ones select receive request
//- selected but disabled drives shared pin high
//- enabling asserts at once if character waiting
//- receive request ignores receiver disable
//- low from arrival until character read
//- one falling edge per requested character
//- special character locks queue head until reset in stop-on-special modes
//- hold request high while queue locked
//- error reset resumes tracking receive buffer
//- receive buffer read strobe raises request
//- dedicated pin off: inverted level, high after reset
`timescale 1ns/100ps

// ============================================================
// receive queue
module sdr_fifo #(
	parameter int W     = 9,             // word width
	parameter int DEPTH = 32             // words, power of two
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	// filling side
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	// draining side
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("sdr_fifo depth must be a power of two");
	end
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;    // storage
		logic [AW-1:0]           wp;     // write pointer
		logic [AW-1:0]           rp;     // read pointer
		logic [AW:0]             cnt;    // words held
	} sdr_fifo_st_t;
	sdr_fifo_st_t f_q, f_d;
	logic push, pop;

	// honest flags straight from the count
	assign o_in_ready  = (f_q.cnt != (AW + 1)'(DEPTH));
	assign o_out_valid = (f_q.cnt != '0);
	assign o_out_data  = f_q.mem[f_q.rp];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// next state
	always_comb
	begin
		f_d = f_q;
		if (push)
		begin
			f_d.mem[f_q.wp] = i_in_data;
			f_d.wp          = f_q.wp + 1'b1;
		end
		if (pop)
			f_d.rp = f_q.rp + 1'b1;
		f_d.cnt = f_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			f_q <= '0;
		else
			f_q <= f_d;
	end
endmodule // sdr_fifo

// ============================================================
// request pins and buffers
module sdr_dma_req #(
	parameter int UPD_CYC = sdr_pkg::TX_UPD_CYC // register update delay
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_rst_b,
	// host access and configuration
	input  wire sdr_pkg::sdr_acc_t       i_acc,
	input  wire sdr_pkg::sdr_cfg_t       i_cfg,
	input  wire logic                    i_err_reset,
	output logic [sdr_pkg::CHAR_W-1:0]   o_rd_data,
	// receiver side
	input  wire logic                    i_rx_valid,
	input  wire sdr_pkg::sdr_rxch_t      i_rx_char,
	output logic                         o_rx_ready,
	// transmitter side
	input  wire logic                    i_tx_take,
	output logic                         o_tx_full,
	output logic [sdr_pkg::CHAR_W-1:0]   o_tx_data,
	// request pins
	output logic                         o_dtr_req_b,
	output logic                         o_wreq_b,
	output logic                         o_wreq_oe
);
	import sdr_pkg::*;
	localparam int CW = $clog2(UPD_CYC + 1);
	localparam int ASSERT_UPD = UPD_CYC;
	if (UPD_CYC < 2)
	begin : g_bad_upd
		$error("sdr_dma_req update delay below two cycles");
	end

	// ========================================================
	// state
	typedef struct packed {
		logic [CHAR_W-1:0] tx_data;      // transmit_buffer contents
		logic              tx_full;      // transmit_buffer full
		logic              tx_pend;      // write under way, not landed
		logic              upd_busy;     // delayed update running
		logic [CW-1:0]     upd_cnt;      // cycles left for update
		logic [CHAR_W-1:0] upd_data;     // character waiting to land
		logic              rd_pend;      // receive_buffer read under way
		logic              lock_hold;    // locked special char read
		logic              rx_ready;     // queue accepts a character
		logic [CHAR_W-1:0] rd_data;      // read data to host
		logic              dtr_b;        // dedicated pin
		logic              wreq_b;       // shared pin
		logic              wreq_oe;      // shared pin driven
	} sdr_st_t;
	sdr_st_t s_q, s_d;

	sdr_rxch_t rxq_head;                 // receive_buffer
	logic      rxq_valid;                // receive_buffer holds a char
	logic      rxq_in_ready;             // queue room
	logic      pop;                      // remove head
	logic      early_opt;                // dedicated pin drops early
	logic      lock_mode;                // stop-on-special modes
	logic      tx_wr_start, tx_wr_done, rx_rd_start, rx_rd_done;

	// ========================================================
	// receive queue, head is the receive_buffer
	sdr_fifo #(
		.W     ($bits(sdr_rxch_t)),
		.DEPTH (RXQ_DEPTH)
	) u_rxq (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (i_rx_valid),
		.i_in_data   (i_rx_char),
		.o_in_ready  (rxq_in_ready),
		.o_out_valid (rxq_valid),
		.o_out_data  (rxq_head),
		.i_out_ready (pop)
	);

	// access decode
	assign tx_wr_start = i_acc.start & i_acc.wr & (i_acc.tgt == SDR_TGT_TXBUF);
	assign tx_wr_done  = i_acc.done & i_acc.wr & (i_acc.tgt == SDR_TGT_TXBUF);
	assign rx_rd_start = i_acc.start & ~i_acc.wr & (i_acc.tgt == SDR_TGT_RXBUF);
	assign rx_rd_done  = i_acc.done & ~i_acc.wr & (i_acc.tgt == SDR_TGT_RXBUF);
	assign early_opt   = i_cfg.bof & i_cfg.ext_access & i_cfg.early_deact;
	assign lock_mode   = (i_cfg.rxi == SDR_RXI_FIRST_SPECIAL) ||
		(i_cfg.rxi == SDR_RXI_SPECIAL_ONLY);

	// ========================================================
	// next state
	always_comb
	begin
		s_d = s_q;
		pop = 1'b0;
		// transmitter drains first, so a landing write wins
		if (i_tx_take)
			s_d.tx_full = 1'b0;
		// shared pin anticipates the fill from strobe onward
		if (tx_wr_start)
			s_d.tx_pend = 1'b1;
		// buffer itself is written only after the access
		if (tx_wr_done)
		begin
			s_d.upd_busy = 1'b1;
			s_d.upd_cnt  = CW'(UPD_CYC - 1);
			s_d.upd_data = i_acc.data;
		end
		else if (s_q.upd_busy)
		begin
			if (s_q.upd_cnt == CW'(1))
			begin
				s_d.tx_data  = s_q.upd_data;
				s_d.tx_full  = 1'b1;
				s_d.tx_pend  = 1'b0;
				s_d.upd_busy = 1'b0;
			end
			else
				s_d.upd_cnt = s_q.upd_cnt - CW'(1);
		end
		// receive read: strobe raises request, end removes char
		if (rx_rd_start)
		begin
			s_d.rd_pend = 1'b1;
			s_d.rd_data = rxq_valid ? rxq_head.data : '0;
		end
		if (rx_rd_done)
		begin
			s_d.rd_pend = 1'b0;
			// special char stays at the head, queue locked
			if (rxq_valid && rxq_head.special && lock_mode)
				s_d.lock_hold = 1'b1;
			else
				pop = rxq_valid;
		end
		else if (i_err_reset && s_q.lock_hold)
		begin
			// unlock: discard the char already read
			s_d.lock_hold = 1'b0;
			pop           = rxq_valid;
		end
		s_d.rx_ready = rxq_in_ready;
		// shared pin: released in wait modes, driven in request modes
		s_d.wreq_oe = i_cfg.xfer_mode[MODE_FUNC_BIT];
		if (i_cfg.xfer_mode == MODE_RX_DMA)
			// tracks the head even with the receiver off
			s_d.wreq_b = ~(rxq_valid & ~pop & ~s_d.rd_pend & ~s_d.lock_hold);
		else if (i_cfg.xfer_mode == MODE_TX_DMA)
			s_d.wreq_b = s_d.tx_full | s_d.tx_pend;
		else
			s_d.wreq_b = PIN_IDLE;
		// dedicated pin
		if (!i_cfg.dtr_req_en)
			s_d.dtr_b = ~i_cfg.dtr_level;
		else if (early_opt)
			s_d.dtr_b = s_d.tx_full | s_d.tx_pend;
		else
			// waits for the landed update, lingers through the write
			s_d.dtr_b = s_d.tx_full;
	end

	// state register, pins idle high
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s_q        <= '0;
			s_q.dtr_b  <= PIN_IDLE;
			s_q.wreq_b <= PIN_IDLE;
		end
		else
			s_q <= s_d;
	end

	// outputs, all from flops
	assign o_rd_data   = s_q.rd_data;
	assign o_rx_ready  = s_q.rx_ready;
	assign o_tx_full   = s_q.tx_full;
	assign o_tx_data   = s_q.tx_data;
	assign o_dtr_req_b = s_q.dtr_b;
	assign o_wreq_b    = s_q.wreq_b;
	assign o_wreq_oe   = s_q.wreq_oe;

	// ========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	chk_upd_delay: assert property (tx_wr_done ##1 (!tx_wr_done)[*2] |->
		##(ASSERT_UPD - 2) s_q.tx_full) else $error("tx buffer update late");
	chk_dtr_lingers: assert property (tx_wr_start && !s_q.tx_full && !s_q.upd_busy &&
		i_cfg.dtr_req_en && !early_opt |=> (!o_dtr_req_b)[*2])
		else $error("dedicated request dropped during write");
	chk_wreq_early: assert property (tx_wr_start && i_cfg.xfer_mode == MODE_TX_DMA
		|=> o_wreq_b && o_wreq_oe) else $error("shared tx request not early");
	chk_dtr_early: assert property (tx_wr_start && i_cfg.dtr_req_en && early_opt
		|=> o_dtr_req_b) else $error("early option ignored");
	chk_rx_sel_high: assert property (i_cfg.xfer_mode == MODE_RX_SEL
		|=> o_wreq_b && o_wreq_oe) else $error("selected request not high");
	chk_rx_read_high: assert property (rx_rd_start && i_cfg.xfer_mode == MODE_RX_DMA
		|=> o_wreq_b) else $error("read strobe did not raise request");
	chk_lock_hold: assert property (rx_rd_done && rxq_valid && rxq_head.special && lock_mode
		&& i_cfg.xfer_mode == MODE_RX_DMA ##1 !i_err_reset |=> o_wreq_b)
		else $error("request repeated on locked char");
	chk_rx_track: assert property (i_cfg.xfer_mode == MODE_RX_DMA && rxq_valid && !rx_rd_start
		&& !rx_rd_done && !s_q.rd_pend && !s_q.lock_hold |=> !o_wreq_b)
		else $error("rx request not low");
	chk_one_edge: assert property ($fell(o_wreq_b) && i_cfg.xfer_mode == MODE_RX_DMA
		|-> $past(pop, 2) || !$past(rxq_valid, 2) || $past(i_cfg.xfer_mode, 2) != MODE_RX_DMA
		|| $past(s_q.lock_hold, 2)) else $error("extra falling edge");
	chk_dtr_gpio: assert property (!i_cfg.dtr_req_en ##1 !i_cfg.dtr_req_en
		|=> o_dtr_req_b == !$past(i_cfg.dtr_level)) else $error("gpio level wrong");

	cov_tx_early: cover property (tx_wr_start && early_opt ##[1:8] s_q.tx_full);
	cov_rx_lock: cover property (s_q.lock_hold ##[1:20] i_err_reset);
	cov_rxq_full: cover property (!rxq_in_ready);
	cov_rx_two: cover property ($fell(o_wreq_b) ##[2:20] $fell(o_wreq_b));
endmodule // sdr_dma_req

// File: sdr_pkg.sv
// shared constants and types for the serial dma request logic
package sdr_pkg;
	// ==========================================================
	// timing
	localparam int CLK_NS     = 40;                              // bus clock period
	localparam int TX_UPD_NS  = 120;                             // delayed register update
	localparam int TX_UPD_CYC = (TX_UPD_NS + CLK_NS - 1) / CLK_NS; // least time, rounded up
	// ==========================================================
	// sizes
	localparam int CHAR_W    = 8;                                // one character
	localparam int RXQ_DEPTH = 32;                               // receive queue words
	// ==========================================================
	// transfer mode field, bits d7..d5 held as [2:0]
	localparam int MODE_EN_BIT   = 2;                            // d7: enable
	localparam int MODE_FUNC_BIT = 1;                            // d6: request, not wait
	localparam logic [2:0] MODE_RX_DMA  = 3'h7;                  // receive request, enabled
	localparam logic [2:0] MODE_TX_DMA  = 3'h6;                  // transmit request, enabled
	localparam logic [2:0] MODE_RX_SEL  = 3'h3;                  // receive request, not enabled
	localparam logic       PIN_IDLE     = 1'h1;                  // request pins idle high
	// ==========================================================
	// types
	typedef enum logic [1:0] {SDR_TGT_OTHER, SDR_TGT_TXBUF, SDR_TGT_RXBUF} sdr_tgt_t;
	typedef enum logic [1:0] {SDR_RXI_OFF, SDR_RXI_FIRST_SPECIAL, SDR_RXI_ALL,
		SDR_RXI_SPECIAL_ONLY} sdr_rxi_t;
	typedef struct packed {
		logic              start;        // strobe falling edge, pulse
		logic              done;         // access completed, pulse
		logic              wr;           // write, else read
		sdr_tgt_t          tgt;          // addressed buffer
		logic [CHAR_W-1:0] data;         // write data
	} sdr_acc_t;
	typedef struct packed {
		logic [2:0] xfer_mode;           // transfer mode register d7..d5
		logic       dtr_req_en;          // dedicated pin request function
		logic       dtr_level;           // tx control register d7
		logic       bof;                 // bit_oriented_framing selected
		logic       ext_access;          // external status control d0
		logic       early_deact;         // extended feature d4
		sdr_rxi_t   rxi;                 // receive interrupt mode
	} sdr_cfg_t;
	typedef struct packed {
		logic              special;      // special receive condition
		logic [CHAR_W-1:0] data;         // character
	} sdr_rxch_t;
endpackage

// File: tb.sv
// self-checking bench of the serial dma request logic
`timescale 1ns/100ps

module tb;
	import sdr_pkg::*;
	localparam int UPD = TX_UPD_CYC;
	logic i_clk, i_rst_b, rx_valid, err_rst, tx_take, p_en, p_slow, p_start, p_done;
	sdr_acc_t h_acc, acc;
	sdr_cfg_t cfg;
	sdr_rxch_t rx_char;
	logic [7:0] rd_data, tx_data;
	logic rx_ready, tx_full, dtr_b, wreq_b, wreq_oe;
	logic [15:0] p_count, c0;
	logic [8:0] q[$];                    // model of the receive queue
	logic locked;
	int err_count, num_checks, n;

	// ============================================================
	// partner owns the access strobes while enabled
	assign acc = p_en ? sdr_acc_t'{start:p_start, done:p_done, wr:1'b0, tgt:SDR_TGT_RXBUF,
		data:8'h00} : h_acc;
	sdr_dma_req #(.UPD_CYC(UPD)) i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_acc(acc),
		.i_cfg(cfg), .i_err_reset(err_rst), .o_rd_data(rd_data), .i_rx_valid(rx_valid),
		.i_rx_char(rx_char), .o_rx_ready(rx_ready), .i_tx_take(tx_take),
		.o_tx_full(tx_full), .o_tx_data(tx_data), .o_dtr_req_b(dtr_b),
		.o_wreq_b(wreq_b), .o_wreq_oe(wreq_oe));
	sdr_dma_ctl_model i_dma (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(p_en),
		.i_slow(p_slow), .i_req_b(wreq_b), .o_start(p_start), .o_done(p_done),
		.o_count(p_count));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic push(input logic sp, input logic [7:0] d);
		@(posedge i_clk) rx_valid <= 1'b1;
		rx_char <= '{special:sp, data:d};
		@(posedge i_clk) rx_valid <= 1'b0;
		q.push_back({sp, d});
	endtask
	task automatic tx_write(input logic [7:0] d, input logic early);
		@(posedge i_clk) h_acc <= '{start:1'b1, done:1'b0, wr:1'b1, tgt:SDR_TGT_TXBUF, data:d};
		@(posedge i_clk) h_acc.start <= 1'b0;
		h_acc.done <= 1'b1;
		#1 chk("wreq_b early", 1, wreq_b);
		@(posedge i_clk) h_acc.done <= 1'b0;
		repeat (UPD - 2) @(posedge i_clk);
		#1 chk("tx_full late", 0, tx_full);
		chk("dtr_b held", early, dtr_b);
		@(posedge i_clk) #1 chk("tx_full", 1, tx_full);
		chk("dtr_b full", 1, dtr_b);
		chk("tx_data", d, tx_data);
		@(posedge i_clk) tx_take <= 1'b1;
		@(posedge i_clk) tx_take <= 1'b0;
		@(posedge i_clk) #1 chk("dtr_b empty", 0, dtr_b);
		chk("wreq_b empty", 0, wreq_b);
	endtask

	// ============================================================
	// read results against the queue model
	always @(posedge i_clk)
		if (acc.done && !acc.wr && acc.tgt == SDR_TGT_RXBUF && q.size() > 0)
		begin
			chk("rd_data", q[0][7:0], rd_data);
			if (q[0][8] && cfg.rxi inside {SDR_RXI_FIRST_SPECIAL, SDR_RXI_SPECIAL_ONLY})
				locked = 1'b1;
			else
				void'(q.pop_front());
		end

	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	initial
	begin
		repeat (20000) @(posedge i_clk);
		err_count++;
		end_of_test();
	end

	initial
	begin
		{i_rst_b, rx_valid, err_rst, tx_take, p_en, p_slow, locked} = '0;
		h_acc = '0;
		cfg = '0;
		rx_char = '0;
		void'($urandom(32'h25dd));
		repeat (10) @(posedge i_clk);
		chk("dtr_b reset", 1, dtr_b);
		chk("oe reset", 0, wreq_oe);
		i_rst_b <= 1'b1;
		for (int l = 0; l < 2; l++)
		begin
			@(posedge i_clk) cfg.dtr_level <= l[0];
			repeat (2) @(posedge i_clk);
			#1 chk("dtr_b level", !l[0], dtr_b);
		end
		// fill while selected but not enabled, then enable with characters waiting
		@(posedge i_clk) cfg.xfer_mode <= MODE_RX_SEL;
		n = 0;
		while (rx_ready === 1'b1 && n < 40)
		begin
			push(1'b0, 8'($urandom));
			n++;
			@(posedge i_clk) #1;
		end
		chk("queue room", RXQ_DEPTH, n);
		chk("wreq_b selected", 1, wreq_b);
		chk("oe selected", 1, wreq_oe);
		p_en <= 1'b1;
		p_slow <= 1'b1;
		@(posedge i_clk) cfg.xfer_mode <= MODE_RX_DMA;
		repeat (2) @(posedge i_clk);
		#1 chk("wreq_b enabled", 0, wreq_b);
		repeat (RXQ_DEPTH * 12) @(posedge i_clk);
		chk("transfers", RXQ_DEPTH, p_count);
		chk("queue drained", 0, q.size());
		chk("wreq_b idle", 1, wreq_b);
		// special character in each receive interrupt mode except off
		p_slow <= 1'b0;
		for (int m = 1; m < 4; m++)
		begin
			@(posedge i_clk) cfg.rxi <= sdr_rxi_t'(m);
			c0 = p_count;
			push(1'b1, 8'($urandom));
			push(1'b0, 8'($urandom));
			repeat (40) @(posedge i_clk);
			chk("locked reads", (m == 2) ? 2 : 1, p_count - c0);
			chk("wreq_b locked", 1, wreq_b);
			@(posedge i_clk) err_rst <= 1'b1;
			if (locked)
				void'(q.pop_front());
			locked = 1'b0;
			@(posedge i_clk) err_rst <= 1'b0;
			repeat (40) @(posedge i_clk);
			chk("reads after reset", 2, p_count - c0);
			chk("queue after reset", 0, q.size());
		end
		// transmit requests, early drop only with all three conditions
		p_en <= 1'b0;
		@(posedge i_clk) cfg.xfer_mode <= 3'h2;
		cfg.dtr_req_en <= 1'b1;
		@(posedge i_clk) cfg.xfer_mode <= MODE_TX_DMA;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge i_clk) {cfg.bof, cfg.ext_access, cfg.early_deact} <= {k > 0, k > 1, k > 2};
			repeat (2) @(posedge i_clk);
			tx_write(8'($urandom), k == 3);
		end
		end_of_test();
	end
endmodule // tb
